// >>> dv/reverse_power_trip_logic_bench.sv
// Self-checking bench of the reverse power trip logic.
`timescale 1ns/1ps
`include "rpt_map.svh"
module reverse_power_trip_logic_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, meas_valid, block_in, valve_closed_input;
    logic pickup_o, trip_o, valve_path_trip_indication, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    rpt_pkg::rpt_phasor_t meas;
    int err_total = 0;
    int compares = 0;
    int n;
    localparam int TICK = 10;

    // Clock of 20 ns period.
    initial pclk = 1'b0;
    always #10 pclk = ~pclk;

    rpt_trip_logic #(.TICK_CYCLES(TICK)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .meas_valid(meas_valid), .meas(meas), .block_in(block_in), .valve_closed_input(valve_closed_input),
        .pickup_o(pickup_o), .trip_o(trip_o), .valve_path_trip_indication(valve_path_trip_indication), .irq(irq));
    rpt_meas_src u_src (.pclk(pclk), .meas_valid(meas_valid), .meas(meas));

    // Compares one value and counts it.
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // One APB transfer; read data and error flag land in rd and err.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            err_total++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Lets k edges pass and settles after the last one.
    task automatic idle(input int k);
        repeat (k) @(posedge pclk);
        #1;
    endtask

    // Waits for pickup (0), trip (1) or valve trip (2) to reach lvl; n counts the cycles.
    task automatic wait_for(input int sel, input logic lvl, input int lim);
        n = 0;
        while ((sel == 0 ? pickup_o : sel == 1 ? trip_o : valve_path_trip_indication) !== lvl) begin
            idle(1);
            n++;
            if (n > lim) begin
                err_total++;
                $display("ERROR wait on output %0d", sel);
                finish_test();
            end
        end
    endtask

    // Reset values of the settings and status, an unmapped access and a read-only write.
    task automatic s_reset();
        logic [11:0] ra [8] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h018, 12'h01C};
        logic [31:0] rv [8] = '{32'h0, 32'hC1, 32'h1000, 32'h40000000, 32'h0, 32'h2710, 32'h3E8, 32'h0};
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, ra[i], 32'h0);
            chk("reset value", rd, rv[i]);
        end
        apb(1'b0, 12'h030, 32'h0);
        chk("unmapped error", {31'h0, err}, 32'h1);
        apb(1'b1, `RPT_OFF_STATUS, 32'h7);
        apb(1'b0, `RPT_OFF_STATUS, 32'h0);
        chk("status read only", rd, 32'h0);
    endtask

    // Pickup needs a full window and reverse power beyond the exact threshold; interrupt masking.
    task automatic s_window();
        apb(1'b1, `RPT_OFF_CTRL, 32'h3);
        u_src.send(15, -16'sd100);
        idle(8);
        chk("pickup partial window", pickup_o, 1'b0);
        u_src.send(1, -16'sd100);
        wait_for(0, 1'b1, 20);
        apb(1'b0, `RPT_OFF_STATUS, 32'h0);
        chk("status pickup", rd[0], 1'b1);
        apb(1'b0, `RPT_OFF_POWER, 32'h0);
        chk("average power", rd, 32'hFFFFD8F0);
        chk("irq masked", irq, 1'b0);
        apb(1'b1, `RPT_OFF_THRESH, 32'h5F5F);
        idle(25);
        chk("pickup above threshold", pickup_o, 1'b0);
        apb(1'b1, `RPT_OFF_THRESH, 32'h5F5E); // Threshold just under the measured reverse power.
        idle(25);
        chk("pickup below threshold", pickup_o, 1'b1);
        apb(1'b1, `RPT_OFF_IRQ_EN, 32'h1);
        idle(1);
        chk("irq enabled", irq, 1'b1);
        apb(1'b1, `RPT_OFF_CLEAR, 32'h7);
        idle(1);
        chk("irq cleared", irq, 1'b0);
        u_src.send(16, 16'sd100);
        idle(25);
        chk("pickup forward power", pickup_o, 1'b0);
    endtask

    // Long delay trips with the valve closed and a short delay of infinity; block input gates it.
    task automatic s_long();
        apb(1'b1, `RPT_OFF_LONG, 32'h5); // Scaled-down stand-in for the ten second setting.
        apb(1'b1, `RPT_OFF_SHORT, 32'hFFFF);
        valve_closed_input <= 1'b1;
        fork
            u_src.send(16, -16'sd100);
        join_none
        wait_for(0, 1'b1, 100);
        wait_for(1, 1'b1, 100);
        chk("long delay window", (n >= 39 && n <= 55), 1'b1);
        chk("valve path quiet", valve_path_trip_indication, 1'b0);
        wait fork;
        @(posedge pclk);
        block_in <= 1'b1;
        idle(3);
        chk("trip blocked", trip_o, 1'b0);
        @(posedge pclk);
        block_in <= 1'b0;
        idle(3);
        chk("trip unblocked", trip_o, 1'b1);
        u_src.send(16, 16'sd100);
        idle(25);
        chk("trip dropout", trip_o, 1'b0);
    endtask

    // Short delay path with the valve closed raises its own indication and interrupt.
    task automatic s_short();
        apb(1'b1, `RPT_OFF_LONG, 32'hFFFF);
        apb(1'b1, `RPT_OFF_SHORT, 32'h2); // Scaled-down short setting.
        apb(1'b1, `RPT_OFF_CLEAR, 32'h7);
        apb(1'b1, `RPT_OFF_IRQ_EN, 32'h4);
        fork
            u_src.send(16, -16'sd100);
        join_none
        wait_for(0, 1'b1, 100);
        wait_for(2, 1'b1, 40);
        chk("short delay window", (n >= 9 && n <= 25), 1'b1);
        chk("general trip", trip_o, 1'b1);
        chk("valve irq", irq, 1'b1);
        wait fork;
        u_src.send(16, 16'sd100);
        valve_closed_input <= 1'b0;
        idle(25);
        chk("valve trip dropout", valve_path_trip_indication, 1'b0);
    endtask

    // Two separated pickup bursts: the second rising edge restarts the hold.
    task automatic s_hold();
        apb(1'b1, `RPT_OFF_SHORT, 32'hFFFF);
        apb(1'b1, `RPT_OFF_HOLD, 32'h0000001E);
        u_src.send(16, -16'sd100);
        u_src.send(16, 16'sd100);
        u_src.send(16, -16'sd100);
        u_src.send(16, 16'sd100);
        idle(150);
        chk("hold retriggered", pickup_o, 1'b1);
        wait_for(0, 1'b0, 200);
        apb(1'b1, `RPT_OFF_HOLD, 32'h0);
    endtask

    // Block relay, off and unconfigured settings against reverse power.
    task automatic s_modes();
        logic [31:0] cv [3] = '{32'h5, 32'h1, 32'h2};
        logic pv [3] = '{1'b1, 1'b0, 1'b0};
        apb(1'b1, `RPT_OFF_LONG, 32'h2);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, `RPT_OFF_CTRL, cv[i]);
            u_src.send(16, -16'sd100);
            idle(40);
            chk("mode pickup", pickup_o, pv[i]);
            chk("mode trip", trip_o, 1'b0);
            u_src.send(16, 16'sd100);
            idle(25);
        end
    endtask

    // A cosine of one half halves the averaged power of a full reverse window.
    task automatic s_angle();
        apb(1'b1, `RPT_OFF_ANGLE, 32'h20000000);
        u_src.send(16, -16'sd100);
        idle(4);
        apb(1'b0, `RPT_OFF_POWER, 32'h0);
        chk("rotated power", rd, 32'hFFFFEC78);
    endtask

    // Main sequence after a two-cycle reset.
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        block_in = 1'b0;
        valve_closed_input = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        s_reset();
        s_window();
        s_long();
        s_long();
        s_short();
        s_hold();
        s_modes();
        s_angle();
        finish_test();
    end

    // Cuts a hung run short.
    initial begin
        repeat (100000) @(posedge pclk);
        err_total++;
        finish_test();
    end
endmodule // reverse_power_trip_logic_bench

// >>> dv/rpt_meas_src.sv
// Model of the measurement front end that feeds one phasor set per network cycle.
`timescale 1ns/1ps
module rpt_meas_src (
    input wire logic pclk,
    output logic meas_valid,
    output rpt_pkg::rpt_phasor_t meas
);
    // Idle outputs at time zero.
    initial begin
        meas_valid = 1'b0;
        meas = '0;
    end
    // Sends n positive-sequence samples, one every four clocks, then scrambles the idle data.
    task automatic send(input int n, input logic signed [15:0] cur);
        for (int k = 0; k < n; k++) begin
            @(posedge pclk);
            meas_valid <= 1'b1;
            meas <= '{16'sh0064, 16'sh0000, cur, 16'sh0000};
            @(posedge pclk);
            meas_valid <= 1'b0;
            meas <= '{16'shFF9B, 16'shFFFF, ~cur, 16'shFFFF};
            repeat (2) @(posedge pclk);
        end
    endtask
endmodule // rpt_meas_src

// >>> hdl/rpt_map.svh
// Register offsets, field positions, reset values and timing constants of the reverse power trip logic.
`ifndef RPT_MAP_SVH
`define RPT_MAP_SVH

// Register byte offsets on the APB bus.
`define RPT_OFF_CTRL 12'h000
`define RPT_OFF_THRESH 12'h004
`define RPT_OFF_SNSEC 12'h008
`define RPT_OFF_ANGLE 12'h00C
`define RPT_OFF_HOLD 12'h010
`define RPT_OFF_LONG 12'h014
`define RPT_OFF_SHORT 12'h018
`define RPT_OFF_STATUS 12'h01C
`define RPT_OFF_CLEAR 12'h020
`define RPT_OFF_IRQ_EN 12'h024
`define RPT_OFF_STATE 12'h028
`define RPT_OFF_POWER 12'h02C

// Control register fields.
`define RPT_CTRL_EN_BIT 0
`define RPT_CTRL_MODE_LSB 1
`define RPT_CTRL_MODE_MSB 2

// Status, clear and enable bit positions.
`define RPT_EV_PICKUP 0
`define RPT_EV_TRIP 1
`define RPT_EV_VTRIP 2

// Reset values of the setting registers.
`define RPT_RST_THRESH 16'h00C1
`define RPT_RST_SNSEC 16'h1000
`define RPT_RST_COS 16'h4000
`define RPT_RST_SIN 16'h0000
`define RPT_RST_HOLD 16'h0000
`define RPT_RST_LONG 16'h2710
`define RPT_RST_SHORT 16'h03E8

// A time setting of all ones means an infinite delay.
`define RPT_TIME_INF 16'hFFFF
`define RPT_HOLD_INF 17'h1FFFF

// Fractional bits of the cosine and sine settings.
`define RPT_ANGLE_FRAC 14
// Hundredths of a percent per averaged sample: 10000 / 16.
`define RPT_PCT_SCALE 16'h0271
// Network cycles in the averaging window and width of one power sample.
`define RPT_AVG_CYCLES 16
`define RPT_SAMPLE_W 36

// Time base: one timer tick per millisecond at a 20 ns clock.
`define RPT_TICK_NS 1000000
`define RPT_CLK_NS 20
`define RPT_TICK_CYCLES (`RPT_TICK_NS / `RPT_CLK_NS)

`endif

// >>> hdl/rpt_pkg.sv
// Types shared by the reverse power trip logic.
package rpt_pkg;

    // Operating mode as written by software.
    typedef enum logic [1:0] {
        RPT_MODE_OFF,
        RPT_MODE_ON,
        RPT_MODE_BLOCK
    } rpt_mode_t;

    // Positive-sequence fundamental phasors of one network cycle.
    typedef struct packed {
        logic signed [15:0] v_re;
        logic signed [15:0] v_im;
        logic signed [15:0] i_re;
        logic signed [15:0] i_im;
    } rpt_phasor_t;

    // States of the averaging sequence.
    typedef enum logic [1:0] {
        RPT_ST_IDLE,
        RPT_ST_MUL,
        RPT_ST_ACC
    } rpt_avg_st_t;

endpackage

// >>> hdl/rpt_sample_mem.sv
// Sample memory holding the power values of the averaging window.
`timescale 1ns/1ps
module rpt_sample_mem #(
    parameter int unsigned W = 36,
    parameter int unsigned DEPTH = 16,
    parameter int unsigned AW = $clog2(DEPTH)
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [W-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic [W-1:0] rd_data
);
    logic [W-1:0] mem [DEPTH];

    // Storage array is written without reset; unfilled words are read every sample but only used once the window is full.
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Read data leaves through a register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule // rpt_sample_mem

// >>> hdl/rpt_trip_logic.sv
// Reverse power pickup, hold and trip delay logic with its APB register file.
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
`include "rpt_map.svh"
module rpt_trip_logic #(
    parameter int unsigned TICK_CYCLES = `RPT_TICK_CYCLES,
    parameter int unsigned PW = `RPT_SAMPLE_W,
    parameter int unsigned AVG_N = `RPT_AVG_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic meas_valid,
    input wire rpt_pkg::rpt_phasor_t meas,
    input wire logic block_in,
    input wire logic valve_closed_input,
    output logic pickup_o,
    output logic trip_o,
    output logic valve_path_trip_indication,
    output logic irq
);
    localparam int unsigned AW = $clog2(AVG_N);
    localparam int unsigned SW = PW + AW;
    localparam int unsigned TW = $clog2(TICK_CYCLES);

    logic en_cfg_r;
    rpt_pkg::rpt_mode_t mode_r;
    logic [15:0] thr_r;
    logic [15:0] snsec_r;
    logic signed [15:0] cos_r;
    logic signed [15:0] sin_r;
    logic [15:0] hold_r;
    logic [15:0] long_r;
    logic [15:0] short_r;
    logic [2:0] sts_r;
    logic [2:0] irq_en_r;
    logic [2:0] clr_w;
    logic [2:0] set_w;
    logic hit;
    logic wr_en;
    logic [31:0] rd_mux;
    logic [31:0] prdata_r;

    rpt_pkg::rpt_avg_st_t st_r;
    logic signed [32:0] p_mul_r;
    logic signed [32:0] q_mul_r;
    logic signed [48:0] pc_w;
    logic signed [48:0] qs_w;
    logic signed [49:0] corr_w;
    logic signed [PW-1:0] smp_r;
    logic signed [PW-1:0] old_w;
    logic signed [SW-1:0] sum_r;
    logic signed [SW-1:0] old_sub_w;
    logic [AW-1:0] ptr_r;
    logic [AW:0] fill_r;
    logic full_w;
    logic signed [63:0] lhs_w;
    logic signed [63:0] rhs_w;
    logic [31:0] thr_pow_w;

    logic func_on_w;
    logic raw_pu_w;
    logic raw_d_r;
    logic [TW-1:0] tick_cnt_r;
    logic tick_w;
    logic [16:0] hold_cnt_r;
    logic stretched_w;
    logic [15:0] long_cnt_r;
    logic [15:0] short_cnt_r;
    logic long_exp_w;
    logic short_exp_w;
    logic trip_ok_w;
    logic pickup_nxt;
    logic trip_nxt;
    logic vtrip_nxt;
    logic pickup_r;
    logic trip_r;
    logic vtrip_r;

    // Address decode and read multiplexer of the register file.
    always_comb begin
        hit = 1'b1;
        rd_mux = 32'h00000000;
        case (paddr)
            `RPT_OFF_CTRL: begin
                rd_mux[`RPT_CTRL_EN_BIT] = en_cfg_r;
                rd_mux[`RPT_CTRL_MODE_MSB:`RPT_CTRL_MODE_LSB] = mode_r;
            end
            `RPT_OFF_THRESH: rd_mux[15:0] = thr_r;
            `RPT_OFF_SNSEC: rd_mux[15:0] = snsec_r;
            `RPT_OFF_ANGLE: rd_mux = {cos_r, sin_r};
            `RPT_OFF_HOLD: rd_mux[15:0] = hold_r;
            `RPT_OFF_LONG: rd_mux[15:0] = long_r;
            `RPT_OFF_SHORT: rd_mux[15:0] = short_r;
            `RPT_OFF_STATUS: rd_mux[2:0] = sts_r;
            `RPT_OFF_CLEAR: rd_mux = 32'h00000000;
            `RPT_OFF_IRQ_EN: rd_mux[2:0] = irq_en_r;
            `RPT_OFF_STATE: rd_mux[5:0] = {full_w, vtrip_r, trip_r, stretched_w, raw_pu_w, func_on_w};
            `RPT_OFF_POWER: rd_mux = 32'(sum_r >>> AW);
            default: hit = 1'b0;
        endcase
    end

    // The slave always answers in the first access cycle; unmapped addresses flag an error.
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign wr_en = psel & penable & pwrite & hit;
    assign clr_w = (wr_en && paddr == `RPT_OFF_CLEAR) ? pwdata[2:0] : 3'h0;
    assign prdata = prdata_r;

    // Read data is captured in the setup cycle and held through the access.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h00000000;
        end else if (psel && !penable) begin
            prdata_r <= rd_mux;
        end
    end

    // Setting registers written by software.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_cfg_r <= 1'b0;
            mode_r <= rpt_pkg::RPT_MODE_OFF;
            thr_r <= `RPT_RST_THRESH;
            snsec_r <= `RPT_RST_SNSEC;
            cos_r <= `RPT_RST_COS;
            sin_r <= `RPT_RST_SIN;
            hold_r <= `RPT_RST_HOLD;
            long_r <= `RPT_RST_LONG;
            short_r <= `RPT_RST_SHORT;
            irq_en_r <= 3'h0;
        end else if (wr_en) begin
            case (paddr)
                `RPT_OFF_CTRL: begin
                    en_cfg_r <= pwdata[`RPT_CTRL_EN_BIT];
                    mode_r <= rpt_pkg::rpt_mode_t'(pwdata[`RPT_CTRL_MODE_MSB:`RPT_CTRL_MODE_LSB]);
                end
                `RPT_OFF_THRESH: thr_r <= pwdata[15:0];
                `RPT_OFF_SNSEC: snsec_r <= pwdata[15:0];
                `RPT_OFF_ANGLE: begin
                    cos_r <= pwdata[31:16];
                    sin_r <= pwdata[15:0];
                end
                `RPT_OFF_HOLD: hold_r <= pwdata[15:0];
                `RPT_OFF_LONG: long_r <= pwdata[15:0];
                `RPT_OFF_SHORT: short_r <= pwdata[15:0];
                `RPT_OFF_IRQ_EN: irq_en_r <= pwdata[2:0];
                default: ;
            endcase
        end
    end

    // Angle correction rotates the power phasor by the commissioning angle.
    assign pc_w = p_mul_r * cos_r;
    assign qs_w = q_mul_r * sin_r;
    assign corr_w = 50'(pc_w) - 50'(qs_w);
    assign full_w = (fill_r == (AW+1)'(AVG_N));
    assign old_sub_w = full_w ? SW'(old_w) : {SW{1'b0}};

    // Per network cycle: form P and Q, rotate, then replace the oldest sample in the window sum.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= rpt_pkg::RPT_ST_IDLE;
            p_mul_r <= '0;
            q_mul_r <= '0;
            smp_r <= '0;
            sum_r <= '0;
            ptr_r <= '0;
            fill_r <= '0;
        end else begin
            case (st_r)
                rpt_pkg::RPT_ST_IDLE: begin
                    if (meas_valid) begin
                        p_mul_r <= 33'(meas.v_re * meas.i_re) + 33'(meas.v_im * meas.i_im);
                        q_mul_r <= 33'(meas.v_im * meas.i_re) - 33'(meas.v_re * meas.i_im);
                        st_r <= rpt_pkg::RPT_ST_MUL;
                    end
                end
                rpt_pkg::RPT_ST_MUL: begin
                    smp_r <= PW'(corr_w >>> `RPT_ANGLE_FRAC);
                    st_r <= rpt_pkg::RPT_ST_ACC;
                end
                rpt_pkg::RPT_ST_ACC: begin
                    sum_r <= sum_r + SW'(smp_r) - old_sub_w;
                    ptr_r <= (ptr_r == AW'(AVG_N - 1)) ? '0 : ptr_r + AW'(1);
                    if (!full_w) begin
                        fill_r <= fill_r + (AW+1)'(1);
                    end
                    st_r <= rpt_pkg::RPT_ST_IDLE;
                end
                default: st_r <= rpt_pkg::RPT_ST_IDLE;
            endcase
        end
    end

    // The oldest sample is fetched while the new one is rotated.
    rpt_sample_mem #(
        .W(PW),
        .DEPTH(AVG_N)
    ) u_mem (
        .clk(pclk),
        .rst_n(presetn),
        .wr_en(st_r == rpt_pkg::RPT_ST_ACC),
        .wr_addr(ptr_r),
        .wr_data(smp_r),
        .rd_en(st_r == rpt_pkg::RPT_ST_MUL),
        .rd_addr(ptr_r),
        .rd_data(old_w)
    );

    // Window sum times 10000/16 against rating times threshold in hundredths of a percent.
    assign thr_pow_w = snsec_r * thr_r;
    assign lhs_w = (64'sh0 - 64'(sum_r)) * $signed({48'h0, `RPT_PCT_SCALE});
    assign rhs_w = $signed({32'h0, thr_pow_w});
    assign func_on_w = en_cfg_r & (mode_r == rpt_pkg::RPT_MODE_ON || mode_r == rpt_pkg::RPT_MODE_BLOCK);
    assign raw_pu_w = func_on_w & full_w & (lhs_w > rhs_w);

    // Millisecond time base shared by the hold and delay timers.
    assign tick_w = (tick_cnt_r == TW'(TICK_CYCLES - 1));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick_w ? '0 : tick_cnt_r + TW'(1);
        end
    end

    // Hold stage: reloads on each raw rising edge; one extra tick guarantees the minimum length.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raw_d_r <= 1'b0;
            hold_cnt_r <= 17'h00000;
        end else begin
            raw_d_r <= raw_pu_w;
            if (!func_on_w) begin
                hold_cnt_r <= 17'h00000;
            end else if (raw_pu_w && !raw_d_r) begin
                if (hold_r == 16'h0000) begin
                    hold_cnt_r <= 17'h00000;
                end else if (hold_r == `RPT_TIME_INF) begin
                    hold_cnt_r <= `RPT_HOLD_INF;
                end else begin
                    hold_cnt_r <= {1'b0, hold_r} + 17'h00001;
                end
            end else if (tick_w && hold_cnt_r != 17'h00000 && hold_cnt_r != `RPT_HOLD_INF) begin
                hold_cnt_r <= hold_cnt_r - 17'h00001;
            end
        end
    end
    assign stretched_w = func_on_w & (raw_pu_w | (hold_cnt_r != 17'h00000));

    // Delay timers start from the stretched pickup only, so their time adds to measuring time.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            long_cnt_r <= 16'h0000;
            short_cnt_r <= 16'h0000;
        end else begin
            if (!stretched_w) begin
                long_cnt_r <= 16'h0000;
            end else if (tick_w && long_cnt_r != `RPT_TIME_INF) begin
                long_cnt_r <= long_cnt_r + 16'h0001;
            end
            if (!stretched_w || !valve_closed_input) begin
                short_cnt_r <= 16'h0000;
            end else if (tick_w && short_cnt_r != `RPT_TIME_INF) begin
                short_cnt_r <= short_cnt_r + 16'h0001;
            end
        end
    end

    // Long path runs regardless of the valve; short path only with the valve closed.
    assign long_exp_w = stretched_w & (long_r != `RPT_TIME_INF) & (long_cnt_r >= long_r);
    assign short_exp_w = stretched_w & valve_closed_input & (short_r != `RPT_TIME_INF)
                         & (short_cnt_r >= short_r);
    assign trip_ok_w = en_cfg_r & (mode_r == rpt_pkg::RPT_MODE_ON) & ~block_in;
    assign pickup_nxt = stretched_w;
    assign trip_nxt = trip_ok_w & (long_exp_w | short_exp_w);
    assign vtrip_nxt = trip_ok_w & short_exp_w;

    // Indication outputs are registered.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pickup_r <= 1'b0;
            trip_r <= 1'b0;
            vtrip_r <= 1'b0;
        end else begin
            pickup_r <= pickup_nxt;
            trip_r <= trip_nxt;
            vtrip_r <= vtrip_nxt;
        end
    end
    assign pickup_o = pickup_r;
    assign trip_o = trip_r;
    assign valve_path_trip_indication = vtrip_r;

    // Sticky event flags; a new event wins over a clear in the same cycle.
    assign set_w = {vtrip_nxt & ~vtrip_r, trip_nxt & ~trip_r, pickup_nxt & ~pickup_r};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sts_r <= 3'h0;
        end else begin
            sts_r <= (sts_r & ~clr_w) | set_w;
        end
    end
    assign irq = |(sts_r & irq_en_r);

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_off_quiet: assert property (!en_cfg_r |=> !pickup_o && !trip_o)
        else $error("pickup or trip while function not configured");
    a_block_input: assert property (block_in |=> !trip_o && !valve_path_trip_indication)
        else $error("trip while block input asserted");
    a_mode_gate: assert property (mode_r == rpt_pkg::RPT_MODE_BLOCK |=> !trip_o ##0 (pickup_o == $past(stretched_w)))
        else $error("block-relay mode let trip through or stopped pickup");
    a_reverse_only: assert property (raw_pu_w |-> sum_r < 0 && full_w)
        else $error("pickup without reverse power over a full window");
    a_hold_restart: assert property ($rose(raw_pu_w) && hold_r != 16'h0000 && hold_r != `RPT_TIME_INF
        |=> hold_cnt_r == {1'b0, $past(hold_r)} + 17'h00001)
        else $error("hold timer not restarted on raw pickup edge");
    a_hold_stretch: assert property (func_on_w && hold_cnt_r > 17'h00001 |=> stretched_w || !func_on_w)
        else $error("stretched pickup dropped while hold time remains");
    a_long_backup: assert property (trip_ok_w && long_exp_w |=> trip_o)
        else $error("long delay expired without trip");
    a_trip_cause: assert property (trip_o |-> $past(stretched_w) && ($past(long_exp_w) || $past(short_exp_w)))
        else $error("trip without an expired delay");
    a_short_path: assert property (trip_ok_w && short_exp_w |=> valve_path_trip_indication && trip_o)
        else $error("short valve delay expired without valve trip");
    a_valve_needed: assert property (valve_path_trip_indication |-> $past(valve_closed_input))
        else $error("valve path trip without closed valve input");
    a_delay_clear: assert property (!stretched_w |=> long_cnt_r == 16'h0000 && short_cnt_r == 16'h0000)
        else $error("delay timers not cleared on dropout");
    a_window_len: assert property (st_r == rpt_pkg::RPT_ST_ACC && !full_w |=> fill_r == $past(fill_r) + (AW+1)'(1))
        else $error("averaging window fill count wrong");
    a_sticky_set: assert property (set_w[`RPT_EV_TRIP] |=> sts_r[`RPT_EV_TRIP])
        else $error("trip event lost in status");
endmodule // rpt_trip_logic
